// >>> src/nor_flash_command_and_read_mode.sv
// command decoder and read-mode control for a multi-bank parallel flash
// assumes bus pins already synchronous to SYS_CLK, array read is same-cycle
`timescale 1ns/1ps
`include "nor_cmd_defs.svh"

// Operation
// - three 60H writes protect or unprotect block
// - 98H at X55H enters query from read/autoselect
// - AA,55,C0 loads burst config from A20-A12
// - AA,55,C5 loads extended config from upper bits
// - AA,55,70 enters OTP region
// - AA,55,75,00 leaves OTP region
// - decoder ignores upper data byte
// - A21-A11 ignored in command address match
// - reset from autoselect returns to suspend state
// - reset after error returns bank to read
// - protect verify reads 00H or 01H
// - handshake read 0H present, 1H absent
// - bypass commands only after bypass entry
// - erase suspend only while an erase is busy in the addressed bank
// - resume only while matching suspend active
// - quad program needs high supply, shared A21-A2
// - sixteen banks on A21-A18, blocks A21-A12
// - reset leaves device in asynchronous array read
// - burst armed on last strobe clock, runs until CE# goes high or strobe falls again
// - eight-word page selected by A2-A0
// - unmatched write aborts to read mode
module nor_flash_command_and_read_mode #(
  parameter logic [15:0] MANUF_CODE  = 16'h00A5, // arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h005A, // arbitrary value
  parameter bit          HANDSHAKE   = 1'b1      // ready handshake built in
) (
  input  wire logic                      SYS_CLK,
  input  wire logic                      RESET,
  input  wire nor_cmd_pkg::host_bus_s    HOST_BUS,
  input  wire nor_cmd_pkg::core_status_s CORE_STATUS,
  input  wire logic [15:0]               ARRAY_RDATA,
  input  wire logic [15:0]               CFI_RDATA,
  output      logic [21:0]               ARRAY_ADDR,
  output      logic [15:0]               DATA_OUT,
  output      logic                      DATA_VALID,
  output      logic                      DATA_OE,
  output      nor_cmd_pkg::events_s      EVENTS,
  output      logic [21:0]               TARGET_ADDR,
  output      logic [15:0]               TARGET_WORD,
  output      logic                      QUAD_MODE,
  output      logic [8:0]                BURST_CFG,
  output      logic [9:0]                EXT_CFG,
  output      logic                      OTP_MODE,
  output      logic                      BYPASS_MODE,
  output      logic                      ERASE_SUSPENDED,
  output      logic                      PROGRAM_SUSPENDED,
  output      logic                      BURST_ACTIVE,
  output      logic [31:0]               BANK_MODES
);

  // low address match against a command pattern
  function automatic logic at_addr(input logic [21:0] a,
                                   input logic [10:0] pat);
    at_addr = (a[10:0] == pat);
  endfunction

  // bank number of an address
  function automatic logic [3:0] bank_of(input logic [21:0] a);
    bank_of = a[`BANK_MSB:`BANK_LSB];
  endfunction

  nor_cmd_pkg::ctl_s s_r;   // registered state
  nor_cmd_pkg::ctl_s s_nxt; // next state

  logic [15:0] page_rdata; // page buffer read word
  logic        page_we;    // page buffer write strobe

  // page fill writes while not bursting
  assign page_we = s_r.filling & ~s_r.active;

  // burst address wins the array port, else page fill address
  assign ARRAY_ADDR = s_r.active ? s_r.burst_addr
                                 : {s_r.page_base, s_r.fill_cnt};

  page_buffer u_page (
    .clk   (SYS_CLK),
    .rst   (RESET),
    .we    (page_we),
    .waddr (s_r.fill_cnt),
    .wdata (ARRAY_RDATA),
    .raddr (HOST_BUS.addr[2:0]),
    .rdata (page_rdata)
  );

  // next state: write decoding, burst tracking, page fill, read mux
  always_comb begin
    logic [7:0]  d;        // command byte
    logic [21:0] a;        // command address
    logic [3:0]  bk;       // command bank
    logic [3:0]  rbk;      // read bank
    logic        hit;      // write matched a sequence
    logic        wr_now;   // host write strobe low
    logic        wr_done;  // write strobe just released
    logic        bclk_rise; // burst clock rising
    d         = s_r.wr_data[7:0];
    a         = s_r.wr_addr;
    bk        = bank_of(s_r.wr_addr);
    rbk       = bank_of(HOST_BUS.addr);
    hit       = 1'b1;
    wr_now    = ~HOST_BUS.ce_n & ~HOST_BUS.we_n & HOST_BUS.oe_n;
    wr_done   = s_r.we_seen & ~wr_now;
    bclk_rise = HOST_BUS.burst_clk & ~s_r.bclk_prev;
    s_nxt     = s_r;
    s_nxt.evt = '0;

    // capture address and data while the write strobe is low
    if (wr_now) begin
      s_nxt.we_seen = 1'b1;
      s_nxt.wr_addr = HOST_BUS.addr;
      s_nxt.wr_data = HOST_BUS.dq;
    end

    // decode one completed write
    if (wr_done) begin
      s_nxt.we_seen = 1'b0;
      s_nxt.cyc     = 3'(s_r.cyc + 3'h1);
      case (s_r.cmd)
        nor_cmd_pkg::C_IDLE: begin
          if (s_r.bypass && d == `CMD_PROGRAM) begin
            s_nxt.cmd = nor_cmd_pkg::C_BPROG;
          end else if (s_r.bypass && d == `CMD_ERASE) begin
            s_nxt.cmd = nor_cmd_pkg::C_BER;
          end else if (s_r.bypass && d == `CMD_AUTOSEL) begin
            s_nxt.cmd = nor_cmd_pkg::C_BRST;
          end else if (d == `CMD_RESET) begin
            // suspend flags stay, so the bank falls back to suspend read
            s_nxt.mode[bk] = nor_cmd_pkg::BM_READ;
            if (CORE_STATUS.operation_error_bit[bk]) begin
              s_nxt.evt.error_clear = 1'b1;
            end
          end else if (d == `CMD_UNLOCK1 && at_addr(a, `ADDR_UNLOCK1)) begin
            s_nxt.cmd = nor_cmd_pkg::C_UNL1;
          end else if (d == `CMD_PROTECT) begin
            s_nxt.cmd = nor_cmd_pkg::C_PROT1;
          end else if (d == `CMD_CFI && a[7:0] == `ADDR_CFI &&
                       s_r.mode[bk] != nor_cmd_pkg::BM_CFI) begin
            s_nxt.mode[bk] = nor_cmd_pkg::BM_CFI;
          end else if (d == `CMD_SUSPEND && CORE_STATUS.erase_busy &&
                       !s_r.erase_susp && bk == CORE_STATUS.erase_bank) begin
            s_nxt.erase_susp        = 1'b1;
            s_nxt.susp_bank         = bk;
            s_nxt.evt.erase_suspend = 1'b1;
          end else if (d == `CMD_SUSPEND && CORE_STATUS.program_busy &&
                       !s_r.prog_susp) begin
            s_nxt.prog_susp        = 1'b1;
            s_nxt.susp_bank        = bk;
            s_nxt.evt.prog_suspend = 1'b1;
          end else if (d == `CMD_BLOCK && s_r.prog_susp &&
                       bk == s_r.susp_bank) begin
            s_nxt.prog_susp       = 1'b0;
            s_nxt.evt.prog_resume = 1'b1;
          end else if (d == `CMD_BLOCK && s_r.erase_susp &&
                       bk == s_r.susp_bank) begin
            s_nxt.erase_susp       = 1'b0;
            s_nxt.evt.erase_resume = 1'b1;
          end else if (d == `CMD_QUAD && CORE_STATUS.high_voltage_level) begin
            s_nxt.cmd = nor_cmd_pkg::C_QUAD;
          end else begin
            hit = 1'b0;
          end
        end
        nor_cmd_pkg::C_UNL1: begin
          if (d == `CMD_UNLOCK2 && at_addr(a, `ADDR_UNLOCK2)) begin
            s_nxt.cmd = nor_cmd_pkg::C_UNL2;
          end else begin
            hit = 1'b0;
          end
        end
        nor_cmd_pkg::C_UNL2: begin
          s_nxt.cmd = nor_cmd_pkg::C_IDLE;
          if (!at_addr(a, `ADDR_UNLOCK1)) begin
            hit = 1'b0;
          end else begin
            case (d)
              `CMD_AUTOSEL:   s_nxt.mode[bk] = nor_cmd_pkg::BM_AUTOSEL;
              `CMD_PROGRAM:   s_nxt.cmd = nor_cmd_pkg::C_PROG;
              `CMD_BYPASS:    s_nxt.bypass = 1'b1;
              `CMD_ERASE:     s_nxt.cmd = nor_cmd_pkg::C_ER1;
              `CMD_BURST_CFG: s_nxt.burst_cfg = a[20:`BLOCK_LSB];
              `CMD_EXT_CFG:   s_nxt.ext_cfg = a[21:`BLOCK_LSB];
              `CMD_OTP_ENTER: s_nxt.otp = 1'b1;
              `CMD_OTP_EXIT:  s_nxt.cmd = nor_cmd_pkg::C_OTPX;
              default:        hit = 1'b0;
            endcase
          end
        end
        nor_cmd_pkg::C_PROG, nor_cmd_pkg::C_BPROG: begin
          // fourth write, or second in bypass, carries the word
          s_nxt.cmd            = nor_cmd_pkg::C_IDLE;
          s_nxt.tgt_addr       = a;
          s_nxt.tgt_word       = s_r.wr_data;
          s_nxt.quad           = 1'b0;
          s_nxt.evt.prog_start = 1'b1;
        end
        nor_cmd_pkg::C_ER1: begin
          if (d == `CMD_UNLOCK1 && at_addr(a, `ADDR_UNLOCK1)) begin
            s_nxt.cmd = nor_cmd_pkg::C_ER2;
          end else begin
            hit = 1'b0;
          end
        end
        nor_cmd_pkg::C_ER2: begin
          if (d == `CMD_UNLOCK2 && at_addr(a, `ADDR_UNLOCK2)) begin
            s_nxt.cmd = nor_cmd_pkg::C_ER3;
          end else begin
            hit = 1'b0;
          end
        end
        nor_cmd_pkg::C_ER3, nor_cmd_pkg::C_BER: begin
          // last erase write: chip needs 555 unless in bypass, block takes its address
          s_nxt.cmd = nor_cmd_pkg::C_IDLE;
          if (d == `CMD_CHIP && (s_r.cmd == nor_cmd_pkg::C_BER ||
                                 at_addr(a, `ADDR_UNLOCK1))) begin
            s_nxt.evt.erase_chip = 1'b1;
          end else if (d == `CMD_BLOCK) begin
            s_nxt.tgt_addr        = a;
            s_nxt.evt.erase_block = 1'b1;
          end else begin
            hit = 1'b0;
          end
        end
        nor_cmd_pkg::C_BRST: begin
          s_nxt.cmd = nor_cmd_pkg::C_IDLE;
          if (d == `CMD_ZERO) begin
            s_nxt.bypass = 1'b0;
          end else begin
            hit = 1'b0;
          end
        end
        nor_cmd_pkg::C_PROT1: begin
          if (d == `CMD_PROTECT) begin
            s_nxt.cmd = nor_cmd_pkg::C_PROT2;
          end else begin
            hit = 1'b0;
          end
        end
        nor_cmd_pkg::C_PROT2: begin
          // third write: A1 high, A0 low, A6 picks the direction
          s_nxt.cmd = nor_cmd_pkg::C_IDLE;
          if (d == `CMD_PROTECT && a[`PROT_A1_BIT] && !a[`PROT_A0_BIT]) begin
            s_nxt.tgt_addr      = a;
            s_nxt.evt.unprotect = a[`PROT_SEL_BIT];
            s_nxt.evt.protect   = ~a[`PROT_SEL_BIT];
          end else begin
            hit = 1'b0;
          end
        end
        nor_cmd_pkg::C_OTPX: begin
          s_nxt.cmd = nor_cmd_pkg::C_IDLE;
          if (d == `CMD_ZERO) begin
            s_nxt.otp = 1'b0;
          end else begin
            hit = 1'b0;
          end
        end
        nor_cmd_pkg::C_QUAD: begin
          // four data writes within one group sharing A21-A2
          if (s_r.cyc == 3'h1) begin
            s_nxt.quad_base = a[21:`QUAD_LSB];
          end
          if (s_r.cyc != 3'h1 && a[21:`QUAD_LSB] != s_r.quad_base) begin
            hit = 1'b0;
          end else begin
            s_nxt.tgt_addr       = a;
            s_nxt.tgt_word       = s_r.wr_data;
            s_nxt.quad           = 1'b1;
            s_nxt.evt.prog_start = 1'b1;
            if (s_r.cyc == 3'h4) begin
              s_nxt.cmd = nor_cmd_pkg::C_IDLE;
            end
          end
        end
        default: begin
          hit = 1'b0;
        end
      endcase
      // unmatched write: drop the sequence, banks back to array read
      if (!hit) begin
        s_nxt.cmd       = nor_cmd_pkg::C_IDLE;
        s_nxt.evt       = '0;
        s_nxt.evt.abort = 1'b1;
        s_nxt.mode      = '{default: nor_cmd_pkg::BM_READ};
      end
      // sequence ended: matching restarts at the first cycle
      if (s_nxt.cmd == nor_cmd_pkg::C_IDLE) begin
        s_nxt.cyc = 3'h0;
      end
    end

    // burst: arm on each clock while strobe low, run once it rises
    s_nxt.bclk_prev = HOST_BUS.burst_clk;
    if (HOST_BUS.ce_n) begin
      s_nxt.armed  = 1'b0;
      s_nxt.active = 1'b0;
    end else if (!HOST_BUS.address_valid_strobe_n) begin
      s_nxt.active = 1'b0;
      if (bclk_rise) begin
        s_nxt.armed      = 1'b1;
        s_nxt.burst_addr = HOST_BUS.addr;
      end
    end else if (s_r.armed && bclk_rise) begin
      s_nxt.armed  = 1'b0;
      s_nxt.active = 1'b1;
    end else if (s_r.active && bclk_rise) begin
      s_nxt.burst_addr = 22'(s_r.burst_addr + 22'h1);
    end

    // page: load eight words whenever A21-A3 leave the held page
    if (s_r.filling && !s_r.active) begin
      s_nxt.fill_cnt = 3'(s_r.fill_cnt + 3'h1);
      if (s_r.fill_cnt == 3'h7) begin
        s_nxt.filling    = 1'b0;
        s_nxt.page_valid = 1'b1;
      end
    end else if (!s_r.filling && !HOST_BUS.ce_n && !s_r.active &&
                 (!s_r.page_valid ||
                  HOST_BUS.addr[21:`PAGE_LSB] != s_r.page_base)) begin
      s_nxt.filling    = 1'b1;
      s_nxt.fill_cnt   = 3'h0;
      s_nxt.page_valid = 1'b0;
      s_nxt.page_base  = HOST_BUS.addr[21:`PAGE_LSB];
    end
    // array contents may change: drop the held page
    if (s_nxt.evt.prog_start || s_nxt.evt.erase_block ||
        s_nxt.evt.erase_chip) begin
      s_nxt.page_valid = 1'b0;
    end

    // read data: burst, autoselect, query or page word
    s_nxt.doe    = ~HOST_BUS.ce_n & ~HOST_BUS.oe_n & HOST_BUS.we_n;
    s_nxt.dvalid = 1'b1;
    if (s_r.active) begin
      s_nxt.dout = ARRAY_RDATA;
    end else begin
      case (s_r.mode[rbk])
        nor_cmd_pkg::BM_AUTOSEL: begin
          case (HOST_BUS.addr[7:0])
            `AS_MANUF:     s_nxt.dout = MANUF_CODE;
            `AS_DEVICE:    s_nxt.dout = DEVICE_CODE;
            `AS_PROTECT:   s_nxt.dout = CORE_STATUS.block_protected ?
                                        `PROT_YES : `PROT_NO;
            `AS_HANDSHAKE: s_nxt.dout = HANDSHAKE ?
                                        `HS_PRESENT : `HS_ABSENT;
            default:       s_nxt.dout = 16'h0000;
          endcase
        end
        nor_cmd_pkg::BM_CFI: begin
          s_nxt.dout = CFI_RDATA;
        end
        default: begin
          // page word picked by A2-A0
          s_nxt.dout   = page_rdata;
          s_nxt.dvalid = s_r.page_valid & ~s_r.filling &
                         (HOST_BUS.addr[21:`PAGE_LSB] == s_r.page_base);
        end
      endcase
    end
  end

  // register the state; reset gives asynchronous array read
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      s_r           <= '0;
      s_r.cmd       <= nor_cmd_pkg::C_IDLE;
      s_r.mode      <= '{default: nor_cmd_pkg::BM_READ};
      s_r.burst_cfg <= `BURST_CFG_RST;
      s_r.ext_cfg   <= `EXT_CFG_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from state
  assign DATA_OUT          = s_r.dout;
  assign DATA_VALID        = s_r.dvalid;
  assign DATA_OE           = s_r.doe;
  assign EVENTS            = s_r.evt;
  assign TARGET_ADDR       = s_r.tgt_addr;
  assign TARGET_WORD       = s_r.tgt_word;
  assign QUAD_MODE         = s_r.quad;
  assign BURST_CFG         = s_r.burst_cfg;
  assign EXT_CFG           = s_r.ext_cfg;
  assign OTP_MODE          = s_r.otp;
  assign BYPASS_MODE       = s_r.bypass;
  assign ERASE_SUSPENDED   = s_r.erase_susp;
  assign PROGRAM_SUSPENDED = s_r.prog_susp;
  assign BURST_ACTIVE      = s_r.active;
  assign BANK_MODES        = s_r.mode;

endmodule

// >>> src/nor_cmd_defs.svh
// command codes, address fields, reset values for the flash command block
// assumes a 16-bit data bus and a 22-bit word address
`ifndef NOR_CMD_DEFS_SVH
`define NOR_CMD_DEFS_SVH

// command data codes, low byte only
`define CMD_RESET      8'hF0
`define CMD_UNLOCK1    8'hAA
`define CMD_UNLOCK2    8'h55
`define CMD_AUTOSEL    8'h90
`define CMD_PROGRAM    8'hA0
`define CMD_BYPASS     8'h20
`define CMD_ERASE      8'h80
`define CMD_CHIP       8'h10
`define CMD_BLOCK      8'h30
`define CMD_SUSPEND    8'hB0
`define CMD_QUAD       8'hA5
`define CMD_PROTECT    8'h60
`define CMD_CFI        8'h98
`define CMD_BURST_CFG  8'hC0
`define CMD_EXT_CFG    8'hC5
`define CMD_OTP_ENTER  8'h70
`define CMD_OTP_EXIT   8'h75
`define CMD_ZERO       8'h00

// command address patterns, low address bits only
`define ADDR_UNLOCK1   11'h555
`define ADDR_UNLOCK2   11'h2AA
`define ADDR_CFI       8'h55

// autoselect read offsets
`define AS_MANUF       8'h00
`define AS_DEVICE      8'h01
`define AS_PROTECT     8'h02
`define AS_HANDSHAKE   8'h03

// address field positions
`define BANK_MSB       21
`define BANK_LSB       18
`define BLOCK_LSB      12
`define PAGE_LSB       3
`define PROT_SEL_BIT   6
`define PROT_A1_BIT    1
`define PROT_A0_BIT    0
`define QUAD_LSB       2

// reset values of the configuration registers
`define BURST_CFG_RST  9'h100
`define EXT_CFG_RST    10'h000

// autoselect answers
`define PROT_YES       16'h0001
`define PROT_NO        16'h0000
`define HS_PRESENT     16'h0000
`define HS_ABSENT      16'h0001

`endif

// >>> src/nor_cmd_pkg.sv
// types shared by the flash command block and its page buffer
// assumes nor_cmd_defs.svh supplies the numeric constants
package nor_cmd_pkg;

  // per-bank read personality
  typedef enum logic [1:0] {BM_READ, BM_AUTOSEL, BM_CFI} bank_mode_e;

  // command sequence position
  typedef enum logic [3:0] {
    C_IDLE, C_UNL1, C_UNL2, C_PROG, C_ER1, C_ER2, C_ER3,
    C_BPROG, C_BER, C_BRST, C_PROT1, C_PROT2, C_OTPX, C_QUAD
  } cmd_state_e;

  // host side bus pins, sampled on the system clock
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        address_valid_strobe_n;
    logic        burst_clk;
    logic [21:0] addr;
    logic [15:0] dq;
  } host_bus_s;

  // state reported by the program and erase engine
  typedef struct packed {
    logic [15:0] bank_busy;
    logic [15:0] operation_error_bit;
    logic        erase_busy;
    logic [3:0]  erase_bank;
    logic        program_busy;
    logic        high_voltage_level;
    logic        block_protected;
  } core_status_s;

  // one-cycle requests to the program and erase engine
  typedef struct packed {
    logic prog_start;
    logic erase_block;
    logic erase_chip;
    logic erase_suspend;
    logic erase_resume;
    logic prog_suspend;
    logic prog_resume;
    logic protect;
    logic unprotect;
    logic error_clear;
    logic abort;
  } events_s;

  // whole state of the command and read block
  typedef struct packed {
    cmd_state_e        cmd;
    logic [2:0]        cyc;
    bank_mode_e [15:0] mode;
    logic              bypass;
    logic              otp;
    logic              erase_susp;
    logic              prog_susp;
    logic [3:0]        susp_bank;
    logic [8:0]        burst_cfg;
    logic [9:0]        ext_cfg;
    events_s           evt;
    logic              quad;
    logic [21:0]       tgt_addr;
    logic [15:0]       tgt_word;
    logic [19:0]       quad_base;
    logic              we_seen;
    logic [21:0]       wr_addr;
    logic [15:0]       wr_data;
    logic              bclk_prev;
    logic              armed;
    logic              active;
    logic [21:0]       burst_addr;
    logic [18:0]       page_base;
    logic              page_valid;
    logic              filling;
    logic [2:0]        fill_cnt;
    logic [15:0]       dout;
    logic              dvalid;
    logic              doe;
  } ctl_s;

  // page buffer state
  typedef struct packed {
    logic [7:0][15:0] mem;
    logic [15:0]      rdata;
  } pb_s;

endpackage

// >>> src/page_buffer.sv
// eight-word page buffer with a registered read port
// assumes one writer and one reader on the system clock
`timescale 1ns/1ps
module page_buffer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        we,
  input  wire logic [2:0]  waddr,
  input  wire logic [15:0] wdata,
  input  wire logic [2:0]  raddr,
  output      logic [15:0] rdata
);

  nor_cmd_pkg::pb_s s_r;   // registered state
  nor_cmd_pkg::pb_s s_nxt; // next state

  // write one word, read one word a cycle later
  always_comb begin
    s_nxt = s_r;
    if (we) begin
      s_nxt.mem[waddr] = wdata;
    end
    s_nxt.rdata = s_r.mem[raddr];
  end

  // register the state
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;

endmodule

// >>> test/nor_cmd_chk.sv
// checker for the flash command block, bound to its top module
// assumes outputs update on the edge that decodes a released write
`timescale 1ns/1ps
module nor_cmd_chk (
  input wire logic                      SYS_CLK,
  input wire logic                      RESET,
  input wire nor_cmd_pkg::host_bus_s    HOST_BUS,
  input wire nor_cmd_pkg::core_status_s CORE_STATUS,
  input wire nor_cmd_pkg::events_s      EVENTS,
  input wire logic [8:0]                BURST_CFG,
  input wire logic [9:0]                EXT_CFG,
  input wire logic                      OTP_MODE,
  input wire logic                      ERASE_SUSPENDED,
  input wire logic [31:0]               BANK_MODES
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // a write of code c, last low sample two edges back, released one back
  sequence s_cmd(logic [7:0] c);
    !$past(HOST_BUS.we_n, 2) && $past(HOST_BUS.we_n)
      && $past(HOST_BUS.dq[7:0], 2) == c;
  endsequence
  property p_rst;
    $fell(RESET) |-> BANK_MODES == 32'h0 && BURST_CFG == 9'h100
      && EXT_CFG == 10'h0 && !OTP_MODE && !ERASE_SUSPENDED;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_bcfg;
    !$past(RESET) && $changed(BURST_CFG) |-> s_cmd(8'hC0)
      ##0 BURST_CFG == $past(HOST_BUS.addr[20:12], 2);
  endproperty
  a_bcfg: assert property (p_bcfg) else $error("burst cfg load");
  property p_ecfg;
    !$past(RESET) && $changed(EXT_CFG) |-> s_cmd(8'hC5)
      ##0 EXT_CFG == $past(HOST_BUS.addr[21:12], 2);
  endproperty
  a_ecfg: assert property (p_ecfg) else $error("ext cfg load");
  property p_otp_in;
    $rose(OTP_MODE) |-> s_cmd(8'h70);
  endproperty
  a_otp_in: assert property (p_otp_in) else $error("otp entry");
  property p_otp_out;
    !$past(RESET) && $fell(OTP_MODE) |-> s_cmd(8'h00);
  endproperty
  a_otp_out: assert property (p_otp_out) else $error("otp exit");
  property p_susp;
    $rose(ERASE_SUSPENDED) |-> s_cmd(8'hB0)
      ##0 (EVENTS.erase_suspend && $past(CORE_STATUS.erase_busy));
  endproperty
  a_susp: assert property (p_susp) else $error("erase suspend");
  property p_res;
    !$past(RESET) && $fell(ERASE_SUSPENDED) |-> s_cmd(8'h30)
      ##0 EVENTS.erase_resume;
  endproperty
  a_res: assert property (p_res) else $error("erase resume");
  property p_abort;
    EVENTS.abort |-> BANK_MODES == 32'h0 && !$past(HOST_BUS.we_n, 2);
  endproperty
  a_abort: assert property (p_abort) else $error("abort");
endmodule
bind nor_flash_command_and_read_mode nor_cmd_chk u_chk (.SYS_CLK,
  .RESET, .HOST_BUS, .CORE_STATUS, .EVENTS, .BURST_CFG, .EXT_CFG,
  .OTP_MODE, .ERASE_SUSPENDED, .BANK_MODES);

// >>> test/host_bfm.sv
// host controller model: issues command writes on the flash bus
// assumes one caller at a time, changes pins on falling edges
`timescale 1ns/1ps
module host_bfm (
  input  wire logic                   clk,
  output      nor_cmd_pkg::host_bus_s bus
);
  // idle: deselected, strobes high, burst clock low
  initial bus = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
    address_valid_strobe_n: 1'b1, default: '0};
  // one write cycle, burst clock low and read strobe high
  task automatic wr(input logic [21:0] a, input logic [15:0] d);
    @(negedge clk);
    bus.addr = a;
    bus.dq = d;
    bus.ce_n = 1'b0;
    bus.we_n = 1'b0;
    @(negedge clk);
    bus.ce_n = 1'b1;
    bus.we_n = 1'b1;
    bus.dq = ~d; // released lines stop showing the data
  endtask
  // one read cycle, output strobe low across one edge
  task automatic rd(input logic [21:0] a);
    @(negedge clk);
    bus.addr = a;
    bus.ce_n = 1'b0;
    bus.oe_n = 1'b0;
    @(negedge clk);
    bus.ce_n = 1'b1;
    bus.oe_n = 1'b1;
  endtask
endmodule

// >>> test/test_nor_flash_command_and_read_mode.sv
// bench for the flash command block: command writes and mode checks
// assumes host_bfm drives the bus and the checker is bound in
`timescale 1ns/1ps
module test_nor_flash_command_and_read_mode;
  logic                      SYS_CLK = 1'b0;
  logic                      RESET = 1'b1;
  nor_cmd_pkg::host_bus_s    bus;
  nor_cmd_pkg::core_status_s cs = '0;
  nor_cmd_pkg::events_s      ev;
  logic [8:0]  bcfg;
  logic [9:0]  ecfg;
  logic [31:0] modes;
  logic [21:0] taddr;
  logic [15:0] tword;
  logic [15:0] dout;
  logic        doe, dval;
  logic        otp, byp, esus;
  int          miscompares = 0;
  int          n_compared = 0;
  always #50 SYS_CLK = ~SYS_CLK;
  host_bfm host (.clk(SYS_CLK), .bus(bus));
  nor_flash_command_and_read_mode dut (.SYS_CLK, .RESET,
    .HOST_BUS(bus), .CORE_STATUS(cs), .ARRAY_RDATA(16'h1234),
    .CFI_RDATA(16'h0051), .ARRAY_ADDR(), .DATA_OUT(dout),
    .DATA_VALID(dval), .DATA_OE(doe), .EVENTS(ev), .TARGET_ADDR(taddr),
    .TARGET_WORD(tword),
    .QUAD_MODE(), .BURST_CFG(bcfg), .EXT_CFG(ecfg), .OTP_MODE(otp),
    .BYPASS_MODE(byp), .ERASE_SUSPENDED(esus), .PROGRAM_SUSPENDED(),
    .BURST_ACTIVE(), .BANK_MODES(modes));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  // write, then let the decoding edge land
  task automatic cmd(input logic [21:0] a, input logic [15:0] d);
    host.wr(a, d);
    @(negedge SYS_CLK);
  endtask
  // unlock pair with junk in upper address and data bits
  task automatic unlock();
    cmd(22'h3FF555, 16'h5AAA);
    cmd(22'h155AAA, 16'hA555);
  endtask
  task automatic t_reset();
    chk("bcfg", 9'h100, bcfg);
    chk("modes", 0, modes);
    $display("reset test done");
  endtask
  task automatic t_cfg();
    unlock();
    cmd({1'b1, 9'h0B3, 12'h555}, 16'hFFC0);
    chk("bcfg", 9'h0B3, bcfg);
    unlock();
    cmd({10'h2C7, 12'h555}, 16'h33C5);
    chk("ecfg", 10'h2C7, ecfg);
    $display("config test done");
  endtask
  task automatic t_abort();
    cmd({4'h5, 18'h1A055}, 16'hEE98);
    chk("query", 2'd2, modes[11:10]);
    cmd(22'h000555, 16'h00AA);
    cmd(22'h0002AA, 16'h0012);
    chk("abort", 1, ev.abort);
    chk("modes", 0, modes);
    unlock();
    cmd(22'h000555, 16'h0070);
    chk("otp in", 1, otp);
    unlock();
    cmd(22'h000555, 16'h0075);
    cmd(22'h2ABCDE, 16'hFF00);
    chk("otp out", 0, otp);
    $display("abort and otp test done");
  endtask
  task automatic t_protect();
    repeat (2) cmd(22'h000000, 16'h0060);
    cmd(22'h005042, 16'h0060);
    chk("unprot", 1, ev.unprotect);
    repeat (2) cmd(22'h000000, 16'h0060);
    cmd(22'h005002, 16'h0060);
    chk("prot", 1, ev.protect);
    $display("protect test done");
  endtask
  task automatic t_susp();
    cs.erase_busy = 1'b1;
    cs.erase_bank = 4'h3;
    cmd({4'h3, 18'h00123}, 16'h00B0);
    chk("susp", 2'b11, {ev.erase_suspend, esus});
    cmd({4'h3, 18'h00000}, 16'h0030);
    chk("resume", 2'b10, {ev.erase_resume, esus});
    cmd({4'h3, 18'h00000}, 16'h0030);
    chk("bad res", 1, ev.abort);
    cs.erase_busy = 1'b0;
    cmd({4'h3, 18'h00000}, 16'h00B0);
    chk("bad susp", 1, ev.abort);
    $display("suspend test done");
  endtask
  task automatic t_bypass();
    cmd(22'h000555, 16'h00A0);
    chk("no byp", 1, ev.abort);
    unlock();
    cmd(22'h000555, 16'h0020);
    chk("byp", 1, byp);
    cmd(22'h000000, 16'h00A0);
    cmd(22'h12345, 16'hBEEF);
    chk("prog", 1, ev.prog_start);
    chk("addr", 22'h12345, taddr);
    chk("word", 16'hBEEF, tword);
    cmd(22'h0, 16'h0090);
    cmd(22'h0, 16'h0000);
    chk("byp off", 0, byp);
    $display("bypass test done");
  endtask
  // page read, then autoselect reads and reset with error
  task automatic t_read();
    host.rd(22'h000010);
    repeat (9) @(negedge SYS_CLK);
    host.rd(22'h000013);
    chk("page", {1'b1, 16'h1234}, {dval, dout});
    unlock();
    cmd({4'h2, 18'h00555}, 16'h0090);
    host.rd({4'h2, 18'h00003});
    chk("hs", {1'b1, 16'h0000}, {doe, dout});
    cs.block_protected = 1'b1;
    host.rd({4'h2, 18'h00002});
    chk("prot rd", 16'h0001, dout);
    cs.operation_error_bit[2] = 1'b1;
    cmd({4'h2, 18'h00000}, 16'h00F0);
    chk("reset", 3'b100, {ev.error_clear, modes[5:4]});
    $display("read test done");
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(negedge SYS_CLK);
    RESET = 1'b0;
    @(negedge SYS_CLK);
    t_reset();
    t_cfg();
    t_abort();
    t_protect();
    t_susp();
    t_bypass();
    t_read();
    wrap_up();
  end
endmodule
